/* verilog/osd_off_diag.sv */
// off-state diagnostics and overcurrent threshold compensation, n channels
//
// The implementer's own choices: the address-and-strobe port and the register offsets.
`timescale 1ns/1ps
// Contract
// - per-channel battery compensation enable, else unity
// - global bit picks passenger or commercial curve
// - threshold times battery and temperature factors
// - readback select: programmed or compensated threshold
// - off and healthy reads code 110
// - code 100 once after off if no-oc
// - open load 011, short 010
// - low side: below low short, between open
// - high side: above high short, between open
// - fault latches code, output untouched
// - settling timer on off, sample at expiry
// - settling 25.6/61.2/105.6/150 us normal
// - settling 11.2/28.9/40/51.2 us h-bridge
// - low side: falling crossing restarts timer
// - high side: rising crossing restarts timer
// - crossings pass fixed deglitch filter
// - temperature factor unity above saturation, slope
// - temperature select: off, 83, 96, 108
module osd_off_diag #(
    parameter int NUM_CH = 8
) (
    // clock and reset
    input  wire logic                   clock,
    input  wire logic                   rstn,
    // register port
    input  wire logic [7:0]             addr,
    input  wire logic [31:0]            wdata,
    input  wire logic                   wr,
    input  wire logic                   rd,
    output logic      [31:0]            rdata,
    // channel state
    input  wire logic [NUM_CH-1:0]      ch_on,
    input  wire logic [NUM_CH-1:0]      ch_high_side,
    input  wire logic [NUM_CH-1:0]      ch_hbridge,
    input  wire logic [NUM_CH-1:0]      no_oc_latch,
    // threshold comparators, asynchronous
    input  wire osd_pkg::osd_cmp_s [NUM_CH-1:0] cmp,
    // measurements
    input  wire logic [9:0]             supply_adc,
    input  wire logic signed [7:0]      junction_temp,
    // results
    output logic [NUM_CH*6-1:0]         threshold_comp,
    output logic                        irq
);
    // ****************************************************************
    // global registers
    // ****************************************************************
    logic [31:0]        ctrl_r;     // global control
    logic [NUM_CH-1:0]  stat_r;     // sticky fault events
    logic [NUM_CH-1:0]  mask_r;     // interrupt mask
    logic [NUM_CH-1:0]  fault_evt;  // per-channel fault pulses
    logic [NUM_CH*3-1:0] code_all;  // gathered diag codes
    logic [11:0]        cfg_rd [NUM_CH]; // cfg readback per channel
    logic [5:0]         comp_all [NUM_CH]; // compensated thresholds
    logic               diag_read;  // diag register read this cycle
    logic [31:0]        rdata_nxt;  // read mux result

    assign diag_read = rd && (addr == osd_pkg::ADDR_DIAG);

    // control register, curve select lives here
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            ctrl_r <= osd_pkg::CTRL_RESET;
        end else if (wr && addr == osd_pkg::ADDR_CTRL) begin
            ctrl_r <= {31'h0, wdata[osd_pkg::CTRL_CURVE_BIT]};
        end
    end

    // mask register
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            mask_r <= NUM_CH'(osd_pkg::MASK_RESET);
        end else if (wr && addr == osd_pkg::ADDR_IRQ_MASK) begin
            mask_r <= wdata[NUM_CH-1:0];
        end
    end

    // sticky status, write one to clear; a new event wins over clear
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            stat_r <= '0;
        end else if (wr && addr == osd_pkg::ADDR_IRQ_STAT) begin
            stat_r <= (stat_r & ~wdata[NUM_CH-1:0]) | fault_evt;
        end else begin
            stat_r <= stat_r | fault_evt;
        end
    end

    // interrupt level, registered; sets on the same edge as the status bit
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            irq <= 1'b0;
        end else begin
            irq <= |((stat_r | fault_evt) & mask_r);
        end
    end

    // read mux; unmapped addresses read zero
    always_comb begin
        rdata_nxt = 32'h0;
        if (addr == osd_pkg::ADDR_CTRL) begin
            rdata_nxt = ctrl_r;
        end else if (addr == osd_pkg::ADDR_DIAG) begin
            rdata_nxt = 32'(code_all);
        end else if (addr == osd_pkg::ADDR_IRQ_STAT) begin
            rdata_nxt = 32'(stat_r);
        end else if (addr == osd_pkg::ADDR_IRQ_MASK) begin
            rdata_nxt = 32'(mask_r);
        end else begin
            for (int i = 0; i < NUM_CH; i++) begin
                if (addr == osd_pkg::ADDR_CFG_BASE + 8'(4 * i)) begin
                    rdata_nxt = {20'h0, cfg_rd[i]};
                end
            end
        end
    end

    // read data for one cycle after the strobe
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            rdata <= 32'h0;
        end else if (rd) begin
            rdata <= rdata_nxt;
        end else begin
            rdata <= 32'h0;
        end
    end

    // compensated thresholds out, registered
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            threshold_comp <= '0;
        end else begin
            for (int i = 0; i < NUM_CH; i++) begin
                threshold_comp[i*6 +: 6] <= comp_all[i];
            end
        end
    end

    // ****************************************************************
    // per-channel logic
    // ****************************************************************
    typedef enum logic [1:0] {
        OSD_ON,      // channel driven, diagnostics idle
        OSD_SETTLE,  // settling timer running
        OSD_DONE     // sampled, waiting for a crossing or turn-on
    } osd_state_e;

    for (genvar c = 0; c < NUM_CH; c++) begin : g_ch
        osd_pkg::osd_cfg_s cfg_r;     // channel configuration
        logic [1:0]  sync1_r;         // first sync stage
        logic [1:0]  sync2_r;         // second sync stage
        logic [1:0]  sync3_r;         // third sync stage
        logic [1:0]  lvl_r;           // agreed comparator level
        logic [1:0]  filt_r;          // deglitched level
        logic [1:0]  filt_d_r;        // deglitched level, delayed
        logic [2:0]  degl_cnt_r [2];  // stability counters
        logic [11:0] tmr_r;           // settling counter
        logic [11:0] tmr_lim;         // selected settling count
        logic [2:0]  code_r;          // diagnostic code
        logic        on_d_r;          // ch_on delayed for edges
        logic        restart;         // crossing in the watched direction
        logic        expire;          // settling done this cycle
        logic [2:0]  class_code;      // classification at expiry
        logic        is_fault;        // classification is a fault
        logic [8:0]  bf;              // battery factor, q8
        logic [16:0] tf;              // temperature factor, q16
        logic [9:0]  tsat;            // saturation temperature
        logic signed [10:0] tdiff;    // degrees below saturation
        logic [31:0] prod;            // product of threshold and factors
        logic [5:0]  comp;            // clamped compensated threshold
        osd_state_e  st_r;            // channel diagnostic state

        // configuration register write
        always_ff @(posedge clock or negedge rstn) begin
            if (!rstn) begin
                cfg_r <= osd_pkg::CFG_RESET;
            end else if (wr && addr == osd_pkg::ADDR_CFG_BASE + 8'(4 * c))
            begin
                cfg_r <= wdata[11:0];
            end
        end

        // three-stage synchroniser; first stage feeds only the second
        always_ff @(posedge clock or negedge rstn) begin
            if (!rstn) begin
                sync1_r <= 2'h0;
                sync2_r <= 2'h0;
                sync3_r <= 2'h0;
            end else begin
                sync1_r <= cmp[c];
                sync2_r <= sync1_r;
                sync3_r <= sync2_r;
            end
        end

        // a change counts once stages two and three agree
        always_ff @(posedge clock or negedge rstn) begin
            if (!rstn) begin
                lvl_r <= 2'h0;
            end else begin
                for (int b = 0; b < 2; b++) begin
                    if (sync2_r[b] == sync3_r[b]) begin
                        lvl_r[b] <= sync3_r[b];
                    end
                end
            end
        end

        // deglitch: level must hold a fixed count
        always_ff @(posedge clock or negedge rstn) begin
            if (!rstn) begin
                filt_r        <= 2'h0;
                degl_cnt_r[0] <= 3'h0;
                degl_cnt_r[1] <= 3'h0;
            end else begin
                for (int b = 0; b < 2; b++) begin
                    if (lvl_r[b] == filt_r[b]) begin
                        degl_cnt_r[b] <= 3'h0;
                    end else if (degl_cnt_r[b] ==
                                 3'(osd_pkg::DEGL_CYC - 1)) begin
                        filt_r[b]     <= lvl_r[b];
                        degl_cnt_r[b] <= 3'h0;
                    end else begin
                        degl_cnt_r[b] <= degl_cnt_r[b] + 3'h1;
                    end
                end
            end
        end

        // delayed copies for edge detection
        always_ff @(posedge clock or negedge rstn) begin
            if (!rstn) begin
                filt_d_r <= 2'h0;
                on_d_r   <= 1'b0;
            end else begin
                filt_d_r <= filt_r;
                on_d_r   <= ch_on[c];
            end
        end

        // watched direction depends on side
        always_comb begin
            if (ch_high_side[c]) begin
                restart = |(filt_r & ~filt_d_r);
            end else begin
                restart = |(~filt_r & filt_d_r);
            end
        end

        // settling count per field and bridge mode
        always_comb begin
            unique case ({ch_hbridge[c], cfg_r.settling_time_select})
                3'h0: tmr_lim = osd_pkg::SET_CYC_0;
                3'h1: tmr_lim = osd_pkg::SET_CYC_1;
                3'h2: tmr_lim = osd_pkg::SET_CYC_2;
                3'h3: tmr_lim = osd_pkg::SET_CYC_3;
                3'h4: tmr_lim = osd_pkg::SET_HB_CYC_0;
                3'h5: tmr_lim = osd_pkg::SET_HB_CYC_1;
                3'h6: tmr_lim = osd_pkg::SET_HB_CYC_2;
                3'h7: tmr_lim = osd_pkg::SET_HB_CYC_3;
            endcase
        end

        assign expire = (st_r == OSD_SETTLE) && !restart &&
                        (tmr_r == tmr_lim - 12'h1);

        // classify the deglitched comparator pair
        always_comb begin
            class_code = osd_pkg::CODE_NO_OL_SHORT;
            if (filt_r[0] && !filt_r[1]) begin
                class_code = osd_pkg::CODE_OPEN_LOAD;
            end else if (ch_high_side[c] && filt_r[1]) begin
                class_code = osd_pkg::CODE_SHORT;
            end else if (!ch_high_side[c] && !filt_r[0]) begin
                class_code = osd_pkg::CODE_SHORT;
            end
        end
        assign is_fault = class_code != osd_pkg::CODE_NO_OL_SHORT;

        // state and settling timer; restarted by each turn-off
        always_ff @(posedge clock or negedge rstn) begin
            if (!rstn) begin
                st_r  <= OSD_ON;
                tmr_r <= 12'h0;
            end else if (ch_on[c]) begin
                st_r  <= OSD_ON;
                tmr_r <= 12'h0;
            end else if (on_d_r || restart) begin
                st_r  <= OSD_SETTLE;
                tmr_r <= 12'h0;
            end else if (expire) begin
                st_r  <= OSD_DONE;
                tmr_r <= 12'h0;
            end else if (st_r == OSD_SETTLE) begin
                tmr_r <= tmr_r + 12'h1;
            end
        end

        // diagnostic code; a detected fault wins over a read clear
        always_ff @(posedge clock or negedge rstn) begin
            if (!rstn) begin
                code_r <= osd_pkg::CODE_NO_OL_SHORT;
            end else if (expire && is_fault) begin
                code_r <= class_code;
            end else if (!ch_on[c] && on_d_r) begin
                // turn-off: report no-failure once if no overcurrent
                if (no_oc_latch[c]) begin
                    code_r <= osd_pkg::CODE_NO_FAIL;
                end else begin
                    code_r <= osd_pkg::CODE_NO_OL_SHORT;
                end
            end else if (diag_read) begin
                code_r <= osd_pkg::CODE_NO_OL_SHORT;
            end
        end
        // drive stays with the output control; nothing here touches it
        assign fault_evt[c] = expire && is_fault;
        assign code_all[c*3 +: 3] = code_r;

        // battery factor: unity if disabled, global curve
        always_comb begin
            if (!cfg_r.battery_comp_enable) begin
                bf = osd_pkg::UNITY_Q8;
            end else if (ctrl_r[osd_pkg::CTRL_CURVE_BIT]) begin
                bf = osd_pkg::BF_CV[supply_adc[9:6]];
            end else begin
                bf = osd_pkg::BF_PV[supply_adc[9:6]];
            end
        end

        // saturation temperature per select field
        always_comb begin
            unique case (cfg_r.temperature_comp_select)
                2'h1: tsat = osd_pkg::TSAT_1;
                2'h2: tsat = osd_pkg::TSAT_2;
                2'h3: tsat = osd_pkg::TSAT_3;
                2'h0: tsat = 10'h0;
            endcase
        end

        // temperature factor falls linearly below saturation
        always_comb begin
            tdiff = $signed({1'b0, tsat}) - 11'(junction_temp);
            if (cfg_r.temperature_comp_select == 2'h0 || tdiff <= 0) begin
                tf = osd_pkg::UNITY_Q16;
            end else begin
                tf = osd_pkg::UNITY_Q16 -
                     17'(osd_pkg::TEMP_SLOPE_Q16 * 17'(tdiff));
            end
        end

        // threshold times both factors, saturated to the field width
        always_comb begin
            prod = 32'(cfg_r.overcurrent_threshold_setting) *
                   32'(bf) * 32'(tf);
            if (prod[31:24] > 8'h3f) begin
                comp = 6'h3f;
            end else begin
                comp = prod[29:24];
            end
        end
        assign comp_all[c] = comp;

        // readback: programmed or compensated threshold
        assign cfg_rd[c] = cfg_r.threshold_readback_select ?
            {cfg_r[11:6], comp} : cfg_r;
    end
endmodule

/* shared/osd_pkg.sv */
// package: constants and types of the off-state diagnostic block
package osd_pkg;
    // ****************************************************************
    // register map
    // ****************************************************************
    localparam logic [7:0] ADDR_CTRL     = 8'h00; // global control
    localparam logic [7:0] ADDR_DIAG     = 8'h04; // diag codes, 3 bits/ch
    localparam logic [7:0] ADDR_IRQ_STAT = 8'h08; // sticky fault events
    localparam logic [7:0] ADDR_IRQ_MASK = 8'h0c; // interrupt mask
    localparam logic [7:0] ADDR_CFG_BASE = 8'h20; // channel cfg, 4 apart
    localparam int         CTRL_CURVE_BIT = 0;    // 1 = commercial curve
    localparam logic [31:0] CTRL_RESET   = 32'h0000_0000;
    localparam logic [31:0] MASK_RESET   = 32'h0000_0000;

    // ****************************************************************
    // diagnostic codes
    // ****************************************************************
    localparam logic [2:0] CODE_NO_OL_SHORT = 3'h6; // 110
    localparam logic [2:0] CODE_NO_FAIL     = 3'h4; // 100
    localparam logic [2:0] CODE_OPEN_LOAD   = 3'h3; // 011
    localparam logic [2:0] CODE_SHORT       = 3'h2; // 010

    // ****************************************************************
    // timing, clock 20 MHz
    // ****************************************************************
    localparam int CLK_NS = 50;
    localparam int DEGL_MIN_NS = 300; // off_deglitch_time lower bound
    localparam int DEGL_MAX_NS = 500; // off_deglitch_time upper bound
    localparam int DEGL_CYC = (DEGL_MIN_NS + CLK_NS - 1) / CLK_NS;
    localparam int SET_NS_0 = 25600;  // settling times, normal config
    localparam int SET_NS_1 = 61200;
    localparam int SET_NS_2 = 105600;
    localparam int SET_NS_3 = 150000;
    localparam int SET_HB_NS_0 = 11200; // settling times, h-bridge
    localparam int SET_HB_NS_1 = 28900;
    localparam int SET_HB_NS_2 = 40000;
    localparam int SET_HB_NS_3 = 51200;
    localparam logic [11:0] SET_CYC_0 = 12'((SET_NS_0 + CLK_NS - 1) / CLK_NS);
    localparam logic [11:0] SET_CYC_1 = 12'((SET_NS_1 + CLK_NS - 1) / CLK_NS);
    localparam logic [11:0] SET_CYC_2 = 12'((SET_NS_2 + CLK_NS - 1) / CLK_NS);
    localparam logic [11:0] SET_CYC_3 = 12'((SET_NS_3 + CLK_NS - 1) / CLK_NS);
    localparam logic [11:0] SET_HB_CYC_0 =
        12'((SET_HB_NS_0 + CLK_NS - 1) / CLK_NS);
    localparam logic [11:0] SET_HB_CYC_1 =
        12'((SET_HB_NS_1 + CLK_NS - 1) / CLK_NS);
    localparam logic [11:0] SET_HB_CYC_2 =
        12'((SET_HB_NS_2 + CLK_NS - 1) / CLK_NS);
    localparam logic [11:0] SET_HB_CYC_3 =
        12'((SET_HB_NS_3 + CLK_NS - 1) / CLK_NS);

    // ****************************************************************
    // compensation factors
    // ****************************************************************
    localparam logic [16:0] UNITY_Q16 = 17'h1_0000; // factor 1.0, q16
    localparam logic [8:0]  UNITY_Q8  = 9'h100;     // factor 1.0, q8
    localparam logic [16:0] TEMP_SLOPE_Q16 = 17'h000f9; // 0.38 % per deg
    localparam logic [9:0]  TSAT_1 = 10'h053; // 83 degrees
    localparam logic [9:0]  TSAT_2 = 10'h060; // 96 degrees
    localparam logic [9:0]  TSAT_3 = 10'h06c; // 108 degrees
    // battery factor curves, q8, indexed by top four supply adc bits
    localparam logic [8:0] BF_PV [16] = '{
        9'h1ff, 9'h1ff, 9'h1c0, 9'h170, 9'h140, 9'h120, 9'h110, 9'h100,
        9'h0f0, 9'h0e0, 9'h0d8, 9'h0d0, 9'h0c8, 9'h0c0, 9'h0b8, 9'h0b0};
    localparam logic [8:0] BF_CV [16] = '{
        9'h1ff, 9'h1ff, 9'h1ff, 9'h1ff, 9'h1c0, 9'h180, 9'h150, 9'h130,
        9'h118, 9'h108, 9'h100, 9'h0f4, 9'h0e8, 9'h0e0, 9'h0d8, 9'h0d0};

    // per-channel configuration word, low bits of its register
    typedef struct packed {
        logic [1:0] settling_time_select;           // bits 11:10
        logic [1:0] temperature_comp_select;        // bits 9:8
        logic       threshold_readback_select;      // bit 7
        logic       battery_comp_enable;            // bit 6
        logic [5:0] overcurrent_threshold_setting;  // bits 5:0
    } osd_cfg_s;
    localparam logic [11:0] CFG_RESET = 12'h000;

    // comparator pair of one channel
    typedef struct packed {
        logic above_high; // output above high_threshold
        logic above_low;  // output above low_threshold
    } osd_cmp_s;
endpackage

/* test/osd_off_diag_checker.sv */
// checker: port properties of the off-state diag block
`timescale 1ns/1ps
module osd_off_diag_checker #(
    parameter int NUM_CH = 8
) (
    // clock and reset
    input wire logic                 clock,
    input wire logic                 rstn,
    // register port
    input wire logic [7:0]           addr,
    input wire logic [31:0]          wdata,
    input wire logic                 wr,
    input wire logic                 rd,
    input wire logic [31:0]          rdata,
    // channel side and results
    input wire logic [NUM_CH-1:0]    ch_on,
    input wire logic [NUM_CH-1:0]    no_oc_latch,
    input wire logic signed [7:0]    junction_temp,
    input wire logic [NUM_CH*6-1:0]  threshold_comp,
    input wire logic                 irq
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rstn);
    logic [11:0] cfg0_r;    // ch 0 config shadow
    logic        mask_r;    // any mask bit set
    logic [7:0]  off_cnt_r; // ch 0 off cycles, saturating
    // shadows follow bus writes only
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            cfg0_r <= 12'h000;
            mask_r <= 1'b0;
        end else if (wr && addr == osd_pkg::ADDR_CFG_BASE) begin
            cfg0_r <= wdata[11:0];
        end else if (wr && addr == osd_pkg::ADDR_IRQ_MASK) begin
            mask_r <= |wdata[NUM_CH-1:0];
        end
    end
    // off-time counter, ch 0
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            off_cnt_r <= 8'h00;
        end else if (ch_on[0]) begin
            off_cnt_r <= 8'h00;
        end else if (off_cnt_r != 8'hff) begin
            off_cnt_r <= off_cnt_r + 8'h01;
        end
    end
    // turn-off, code read 3 cycles on
    sequence s_off_read(logic noc);
        $fell(ch_on[0]) && no_oc_latch[0] == noc ##3
            rd && addr == osd_pkg::ADDR_DIAG;
    endsequence
    AST_OFF_NOFAIL: assert property (
        s_off_read(1'b1) |=> rdata[2:0] == osd_pkg::CODE_NO_FAIL)
        else $error("no-fail code missing");
    AST_OFF_NORMAL: assert property (
        s_off_read(1'b0) |=> rdata[2:0] == osd_pkg::CODE_NO_OL_SHORT)
        else $error("normal code missing");
    AST_NO_EARLY: assert property (
        rd && addr == osd_pkg::ADDR_DIAG && !ch_on[0] &&
        off_cnt_r inside {[8'd3:8'd199]} |=>
        rdata[2] == 1'b1)
        else $error("early fault code");
    AST_RDATA_IDLE: assert property (!$past(rd) |-> rdata == 32'h0)
        else $error("stray read data");
    AST_UNMAPPED: assert property (rd && addr == 8'h10 |=> rdata == 32'h0)
        else $error("unmapped read not zero");
    AST_CFG_READ: assert property (
        rd && addr == osd_pkg::ADDR_CFG_BASE && !cfg0_r[7] |=>
        rdata[5:0] == cfg0_r[5:0])
        else $error("bad threshold readback");
    AST_THR_UNITY: assert property (
        cfg0_r[9:8] == 2'b00 && !cfg0_r[6] && $stable(cfg0_r) |=>
        threshold_comp[5:0] == $past(cfg0_r[5:0]))
        else $error("bad plain threshold");
    AST_TEMP_SAT: assert property (
        cfg0_r[9:6] == 4'h4 && junction_temp >= 8'sd83 &&
        $stable(cfg0_r) && $stable(junction_temp) |=>
        threshold_comp[5:0] == $past(cfg0_r[5:0]))
        else $error("temp factor not unity");
    AST_IRQ_MASKED: assert property (!mask_r && !$past(mask_r) |-> !irq)
        else $error("masked interrupt");
endmodule

/* test/osd_node_model.sv */
// partner model: output node via two comparators
`timescale 1ns/1ps
module osd_node_model #(
    parameter int NUM_CH = 2
) (
    // node level per channel: 00 below low, 01 between, 10 above high
    input  wire logic [2*NUM_CH-1:0]            level,
    // comparator outputs, asynchronous
    output wire osd_pkg::osd_cmp_s [NUM_CH-1:0] cmp
);
    // delay keeps edges off clock edges
    for (genvar i = 0; i < NUM_CH; i++) begin : g_ch
        assign #7 cmp[i].above_low  = |level[2*i+:2];
        assign #7 cmp[i].above_high = level[2*i+1];
    end
endmodule

/* test/osd_off_diag_tb.sv */
// testbench of the off-state diag block
`timescale 1ns/1ps
module osd_off_diag_tb;
    localparam int NC = 2; // two channels
    localparam logic [7:0] DG = osd_pkg::ADDR_DIAG;
    localparam logic [7:0] CF = osd_pkg::ADDR_CFG_BASE;
    logic clock, rstn, wr, rd, irq;
    logic [7:0]  addr;
    logic [31:0] wdata, rdata, q;
    logic [NC-1:0] ch_on, ch_high_side, ch_hbridge, no_oc_latch;
    logic [2*NC-1:0] level; // node level, partner encoding
    wire osd_pkg::osd_cmp_s [NC-1:0] cmp;
    logic [9:0] supply_adc;
    logic signed [7:0] junction_temp;
    logic [NC*6-1:0] threshold_comp;
    int n_errors = 0, compares = 0, cyc = 0, f;
    osd_off_diag #(.NUM_CH(NC)) DUT (
        .clock, .rstn, .addr, .wdata, .wr, .rd, .rdata, .ch_on,
        .ch_high_side, .ch_hbridge, .no_oc_latch, .cmp, .supply_adc,
        .junction_temp, .threshold_comp, .irq);
    osd_node_model #(.NUM_CH(NC)) u_node (.level(level), .cmp(cmp));
    // 20 MHz clock
    initial begin
        clock = 1'b0;
        forever #25 clock = ~clock;
    end
    // hang guard, ~3k cycles needed
    always @(posedge clock) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            n_errors++;
            conclude();
        end
    end
    task automatic conclude();
        $display("errors %0d compares %0d", n_errors, compares);
        if (n_errors == 0 && compares > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    task automatic chk(input string w, input logic [31:0] e, g);
        compares++;
        if (g !== e) begin
            n_errors++;
            $display("wrong value %s expected %h seen %h", w, e, g);
        end
    endtask
    // one bus cycle; q takes the read data
    task automatic bus(input logic w, input logic [7:0] a, input int d);
        {wr, rd} <= {w, !w};
        addr <= a;
        wdata <= d;
        @(posedge clock);
        {wr, rd} <= 2'b00;
        #1 q = rdata;
    endtask
    task automatic rdc(input logic [7:0] a, input int e);
        bus(1'b0, a, 0);
        chk("read", e, q);
    endtask
    // turn off, read codes 3 cycles on
    task automatic off_chk(input int c, input int e);
        @(posedge clock);
        ch_on[c] <= 1'b0;
        repeat (3) @(posedge clock);
        rdc(DG, e);
    endtask
    task automatic thr_chk(input int e);
        repeat (4) @(posedge clock);
        #1 chk("thr", e, {26'h0, threshold_comp[5:0]});
    endtask
    task automatic irq_chk(input logic e);
        repeat (2) @(posedge clock);
        #1 chk("irq", {31'h0, e}, {31'h0, irq});
    endtask
    initial begin
        {rstn, wr, rd, addr, wdata, ch_high_side, ch_hbridge} = '0;
        {no_oc_latch, ch_on, level} = 8'h3a;
        supply_adc = 10'h280; // curve index 10
        junction_temp = 8'sd33;
        repeat (5) @(posedge clock);
        rstn <= 1'b1;
        rdc(DG, 32'h36);
        bus(1'b1, 8'h10, -1);
        rdc(8'h10, 0);
        no_oc_latch <= 2'b01;
        off_chk(0, 32'h34);
        no_oc_latch <= 2'b00;
        rdc(DG, 32'h36);
        // low-side open load; short dip is filtered
        bus(1'b1, osd_pkg::ADDR_IRQ_MASK, 1);
        ch_on[0] <= 1'b1;
        level[1:0] <= 2'b01;
        repeat (20) @(posedge clock);
        off_chk(0, 32'h36);
        repeat (100) @(posedge clock);
        level[1:0] <= 2'b00;
        repeat (3) @(posedge clock);
        level[1:0] <= 2'b01;
        repeat (460) @(posedge clock);
        rdc(DG, 32'h33);
        irq_chk(1'b1);
        rdc(osd_pkg::ADDR_IRQ_STAT, 1);
        bus(1'b1, osd_pkg::ADDR_IRQ_STAT, 1);
        irq_chk(1'b0);
        // high excursion; falling crossing restarts
        level[1:0] <= 2'b10;
        repeat (40) @(posedge clock);
        level[1:0] <= 2'b01;
        repeat (200) @(posedge clock);
        rdc(DG, 32'h36);
        repeat (400) @(posedge clock);
        rdc(DG, 32'h33);
        bus(1'b1, osd_pkg::ADDR_IRQ_STAT, 1);
        // high-side bridge; rise to short restarts settling
        {ch_high_side[1], ch_hbridge[1]} <= 2'b11;
        level[3:2] <= 2'b00;
        off_chk(1, 32'h36);
        repeat (150) @(posedge clock);
        rdc(DG, 32'h36);
        level[3:2] <= 2'b10;
        repeat (260) @(posedge clock);
        rdc(DG, 32'h16);
        irq_chk(1'b0);
        rdc(osd_pkg::ADDR_IRQ_STAT, 2);
        // low-side short to ground, select 01
        {ch_high_side, ch_hbridge} <= '0;
        ch_on[1] <= 1'b1;
        level[3:2] <= 2'b00;
        bus(1'b1, CF + 8'h04, 32'h400);
        off_chk(1, 32'h36);
        repeat (1100) @(posedge clock);
        rdc(DG, 32'h36);
        repeat (200) @(posedge clock);
        rdc(DG, 32'h16);
        // threshold compensation and readback
        bus(1'b1, CF, 32'h20);
        rdc(CF, 32'h20);
        thr_chk(32);
        bus(1'b1, CF, 32'h60);
        thr_chk((32 * osd_pkg::BF_PV[10]) >> 8);
        bus(1'b1, osd_pkg::ADDR_CTRL, 1);
        thr_chk((32 * osd_pkg::BF_CV[10]) >> 8);
        bus(1'b1, osd_pkg::ADDR_CTRL, 0);
        bus(1'b1, CF, 32'he0);
        rdc(CF, 32'hc0 | ((32 * osd_pkg::BF_PV[10]) >> 8));
        junction_temp <= 8'sd90;
        for (int s = 1; s < 4; s++) begin
            bus(1'b1, CF, 32'h20 | (s << 8));
            f = s == 1 ? osd_pkg::TSAT_1 : s == 2 ? osd_pkg::TSAT_2
                : osd_pkg::TSAT_3;
            f = 65536 - (f > 90 ? osd_pkg::TEMP_SLOPE_Q16 * (f - 90) : 0);
            thr_chk((32 * f) >> 16);
        end
        conclude();
    end
endmodule
bind osd_off_diag osd_off_diag_checker #(.NUM_CH(NUM_CH)) u_chk (
    .clock, .rstn, .addr, .wdata, .wr, .rd, .rdata, .ch_on, .no_oc_latch,
    .junction_temp, .threshold_comp, .irq);
